// *** core/secp_port.sv ***
// serial eeprom command port: axi4-lite registers driving an spi eeprom
// Behaviour
// - 14-bit block address selects four-byte location
// - writing command field issues the command
// - code 010b writes buffer to eeprom
// - code 011b reads eeprom into buffer
// - code 001b sends status byte 31:24
// - only status bits 31,27,26 are written
// - code 101b reads part status into 31:24
// - 100b clears, 110b sets write latch
// - presence field 00b, 01b or 11b
// - progress 00b done, 01b busy, 10b crc
// - control bit 20 is address bit 13
// - bit 21 disables read crc check
// - bit 24 shows part ready flag
// - bit 25 shows write latch flag
// - write cycle status 000b when idle
// - status writable when latch and pin allow
// - status protected otherwise
// - 32-bit buffer moves exactly four bytes
module secp_port #(
   parameter logic [7:0] PART_ID = 8'h5A // identity byte, value arbitrary
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic eep_present,
   input wire logic eep_miso,
   output logic eep_sck,
   output logic eep_mosi,
   output logic eep_cs_n
);
   typedef enum logic [1:0] {
      SECP_IDLE = 2'b00,
      SECP_SHIFT = 2'b01,
      SECP_FINISH = 2'b11
   } secp_state_t;

   localparam int unsigned MAXB = 64;

   // crc over the four read bytes, polynomial x^8+x^2+x+1
   function automatic logic [7:0] secp_crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : secp_crc8

   function automatic logic [31:0] secp_merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : secp_merge

   logic [13:0] addr_ff, nxt_addr;
   logic [2:0] cmd_ff, nxt_cmd;
   logic crc_dis_ff, nxt_crc_dis;
   logic [7:0] stat_ff, nxt_stat;
   logic [1:0] prog_ff, nxt_prog;
   logic [1:0] pres_ff, nxt_pres;
   logic [31:0] buf_ff, nxt_buf;
   secp_state_t st_ff, nxt_st;
   logic start_ff, nxt_start;
   logic [MAXB-1:0] tx_ff, nxt_tx;
   logic [6:0] nbits_ff, nxt_nbits;
   logic awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv;
   logic [11:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd;
   logic [3:0] ws_ff, nxt_ws;
   logic [1:0] br_ff, nxt_br;
   logic arr_ff, nxt_arr, rv_ff, nxt_rv;
   logic [31:0] rd_ff, nxt_rd;
   logic [1:0] rr_ff, nxt_rr;
   logic sh_done;
   logic [MAXB-1:0] sh_rx;
   logic [31:0] ctrl_view;

   secp_shifter #(.MAXB(MAXB)) u_shift (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(start_ff),
      .tx_bits(tx_ff),
      .nbits(nbits_ff),
      .miso(eep_miso),
      .sck(eep_sck),
      .mosi(eep_mosi),
      .cs_n(eep_cs_n),
      .done(sh_done),
      .rx_bits(sh_rx)
   );

   always_comb begin
      ctrl_view = '0;
      ctrl_view[secp_pkg::F_ADDR_LO +: 13] = addr_ff[12:0];
      ctrl_view[secp_pkg::F_CMD_LO +: 3] = cmd_ff;
      ctrl_view[secp_pkg::F_PRES_LO +: 2] = pres_ff;
      ctrl_view[secp_pkg::F_PROG_LO +: 2] = prog_ff;
      ctrl_view[secp_pkg::F_ADDR_TOP] = addr_ff[13];
      ctrl_view[secp_pkg::F_CRC_DIS] = crc_dis_ff;
      ctrl_view[secp_pkg::F_STAT_LO +: 8] = stat_ff;
   end

   // axi write channel, register writes and command issue
   always_comb begin
      logic [31:0] cv;
      logic hit;
      cv = '0;
      hit = 1'b0;
      nxt_awr = awr_ff;
      nxt_wr = wr_ff;
      nxt_bv = bv_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_ws = ws_ff;
      nxt_br = br_ff;
      nxt_addr = addr_ff;
      nxt_cmd = cmd_ff;
      nxt_crc_dis = crc_dis_ff;
      nxt_stat = stat_ff;
      nxt_prog = prog_ff;
      nxt_pres = eep_present ? ((pres_ff == secp_pkg::PRES_NONE) ? secp_pkg::PRES_OK
                                 : pres_ff) : secp_pkg::PRES_NONE;
      nxt_buf = buf_ff;
      nxt_st = st_ff;
      nxt_start = 1'b0;
      nxt_tx = tx_ff;
      nxt_nbits = nbits_ff;
      if (s_axi_awvalid && !awr_ff) begin
         nxt_awr = 1'b1;
         nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wr_ff) begin
         nxt_wr = 1'b1;
         nxt_wd = s_axi_wdata;
         nxt_ws = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_bv = 1'b0;
      end
      if (awr_ff && wr_ff && !bv_ff) begin
         nxt_awr = 1'b0;
         nxt_wr = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = secp_pkg::RESP_OKAY;
         if (awa_ff == secp_pkg::CTRL_OFFS) begin
            cv = secp_merge(ctrl_view, wd_ff, ws_ff);
            nxt_addr = {cv[secp_pkg::F_ADDR_TOP], cv[secp_pkg::F_ADDR_LO +: 13]};
            nxt_crc_dis = cv[secp_pkg::F_CRC_DIS];
            nxt_stat = cv[secp_pkg::F_STAT_LO +: 8];
            // a command is only taken while idle; writes while busy leave it alone
            hit = ws_ff[1] && (st_ff == SECP_IDLE);
            if (hit) begin
               nxt_cmd = cv[secp_pkg::F_CMD_LO +: 3];
            end
         end else if (awa_ff == secp_pkg::BUF_OFFS) begin
            nxt_buf = secp_merge(buf_ff, wd_ff, ws_ff);
         end else if (awa_ff == secp_pkg::PART_OFFS) begin
            nxt_br = secp_pkg::RESP_OKAY;
         end else begin
            nxt_br = secp_pkg::RESP_SLVERR;
         end
      end
      // sequencer
      case (st_ff)
         SECP_IDLE: begin
            if (hit) begin
               nxt_nbits = secp_pkg::NB_OP;
               nxt_tx = '0;
               unique case (secp_pkg::secp_cmd_t'(cv[secp_pkg::F_CMD_LO +: 3]))
                  secp_pkg::CMD_WRSTAT: begin
                     nxt_nbits = secp_pkg::NB_STAT;
                     nxt_tx[MAXB-1 -: 16] = {secp_pkg::OP_WRSR,
                        cv[secp_pkg::F_STAT_LO +: 8] & secp_pkg::STAT_WR_MASK};
                  end
                  secp_pkg::CMD_WRITE: begin
                     nxt_nbits = secp_pkg::NB_WRITE;
                     nxt_tx[MAXB-1 -: 56] = {secp_pkg::OP_WRITE, nxt_addr, 2'b00, buf_ff};
                  end
                  secp_pkg::CMD_READ: begin
                     nxt_nbits = secp_pkg::NB_READ;
                     nxt_tx[MAXB-1 -: 24] = {secp_pkg::OP_READ, nxt_addr, 2'b00};
                  end
                  secp_pkg::CMD_WRDIS: nxt_tx[MAXB-1 -: 8] = secp_pkg::OP_WRDI;
                  secp_pkg::CMD_RDSTAT: begin
                     nxt_nbits = secp_pkg::NB_STAT;
                     nxt_tx[MAXB-1 -: 8] = secp_pkg::OP_RDSR;
                  end
                  secp_pkg::CMD_WREN: nxt_tx[MAXB-1 -: 8] = secp_pkg::OP_WREN;
                  default: nxt_nbits = secp_pkg::NB_NONE;
               endcase
               if (nxt_nbits != secp_pkg::NB_NONE) begin
                  nxt_start = 1'b1;
                  nxt_prog = secp_pkg::PROG_BUSY;
                  nxt_st = SECP_SHIFT;
               end
            end
         end
         SECP_SHIFT: begin
            if (sh_done) begin
               nxt_st = SECP_FINISH;
            end
         end
         SECP_FINISH: begin
            nxt_st = SECP_IDLE;
            nxt_prog = secp_pkg::PROG_DONE;
            if (cmd_ff == secp_pkg::CMD_READ) begin
               // data is the upper 32 bits of the last 40 clocked in; crc byte last
               nxt_buf = sh_rx[secp_pkg::RX_CRC_W +: 32];
               if (!crc_dis_ff && secp_crc8(sh_rx[secp_pkg::RX_CRC_W +: 32])
                     != sh_rx[secp_pkg::RX_CRC_W-1:0]) begin
                  nxt_prog = secp_pkg::PROG_CRC;
                  nxt_pres = secp_pkg::PRES_CRC;
               end else if (eep_present) begin
                  nxt_pres = secp_pkg::PRES_OK;
               end
            end else if (cmd_ff == secp_pkg::CMD_RDSTAT) begin
               nxt_stat = sh_rx[7:0];
            end
         end
         default: nxt_st = SECP_IDLE;
      endcase
   end

   // axi read channel
   always_comb begin
      nxt_arr = 1'b0;
      nxt_rv = rv_ff;
      nxt_rd = rd_ff;
      nxt_rr = rr_ff;
      if (s_axi_rvalid && s_axi_rready) begin
         nxt_rv = 1'b0;
      end
      if (s_axi_arvalid && !arr_ff && !rv_ff) begin
         nxt_arr = 1'b1;
         nxt_rv = 1'b1;
         nxt_rr = secp_pkg::RESP_OKAY;
         if (s_axi_araddr == secp_pkg::CTRL_OFFS) begin
            nxt_rd = ctrl_view;
         end else if (s_axi_araddr == secp_pkg::BUF_OFFS) begin
            nxt_rd = buf_ff;
         end else if (s_axi_araddr == secp_pkg::PART_OFFS) begin
            nxt_rd = {24'h000000, PART_ID};
         end else begin
            nxt_rd = '0;
            nxt_rr = secp_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ff <= '0;
         cmd_ff <= '0;
         crc_dis_ff <= 1'b0;
         stat_ff <= '0;
         prog_ff <= secp_pkg::PROG_DONE;
         pres_ff <= secp_pkg::PRES_NONE;
         buf_ff <= secp_pkg::BUF_RESET;
         st_ff <= SECP_IDLE;
         start_ff <= 1'b0;
         tx_ff <= '0;
         nbits_ff <= '0;
         awr_ff <= 1'b0;
         wr_ff <= 1'b0;
         bv_ff <= 1'b0;
         awa_ff <= '0;
         wd_ff <= '0;
         ws_ff <= '0;
         br_ff <= '0;
         arr_ff <= 1'b0;
         rv_ff <= 1'b0;
         rd_ff <= '0;
         rr_ff <= '0;
      end else begin
         addr_ff <= nxt_addr;
         cmd_ff <= nxt_cmd;
         crc_dis_ff <= nxt_crc_dis;
         stat_ff <= nxt_stat;
         prog_ff <= nxt_prog;
         pres_ff <= nxt_pres;
         buf_ff <= nxt_buf;
         st_ff <= nxt_st;
         start_ff <= nxt_start;
         tx_ff <= nxt_tx;
         nbits_ff <= nxt_nbits;
         awr_ff <= nxt_awr;
         wr_ff <= nxt_wr;
         bv_ff <= nxt_bv;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         br_ff <= nxt_br;
         arr_ff <= nxt_arr;
         rv_ff <= nxt_rv;
         rd_ff <= nxt_rd;
         rr_ff <= nxt_rr;
      end
   end

   // awready/wready are registered "slot free" flags: high when nothing is held
   assign s_axi_awready = ~awr_ff;
   assign s_axi_wready = ~wr_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = arr_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rr_ff;
endmodule : secp_port

// *** core/secp_pkg.sv ***
// constants, field layout and types for the serial eeprom command port
package secp_pkg;
   localparam int unsigned AXI_AW = 12;
   localparam logic [11:0] CTRL_OFFS = 12'h260;
   localparam logic [11:0] BUF_OFFS = 12'h264;
   localparam logic [11:0] PART_OFFS = 12'h268;
   localparam logic [31:0] BUF_RESET = 32'h00000000;
   // control register field positions
   localparam int unsigned F_ADDR_LO = 0;
   localparam int unsigned F_ADDR_W = 13;
   localparam int unsigned F_CMD_LO = 13;
   localparam int unsigned F_PRES_LO = 16;
   localparam int unsigned F_PROG_LO = 18;
   localparam int unsigned F_ADDR_TOP = 20;
   localparam int unsigned F_CRC_DIS = 21;
   localparam int unsigned F_STAT_LO = 24;
   localparam int unsigned B_RDY = 0;
   localparam int unsigned B_WEN = 1;
   localparam int unsigned B_BP_LO = 2;
   localparam int unsigned B_WRS_LO = 4;
   localparam int unsigned B_WPEN = 7;
   // only bits 7,3,2 of the part status are writable
   localparam logic [7:0] STAT_WR_MASK = 8'h8C;
   // serial opcodes of the part
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [1:0] PRES_NONE = 2'h0;
   localparam logic [1:0] PRES_OK = 2'h1;
   localparam logic [1:0] PRES_CRC = 2'h3;
   localparam logic [1:0] PROG_DONE = 2'h0;
   localparam logic [1:0] PROG_BUSY = 2'h1;
   localparam logic [1:0] PROG_CRC = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int unsigned SCK_HALF = 2;
   // bits per serial frame: nothing, opcode only, opcode and byte, write, read
   localparam logic [6:0] NB_NONE = 7'h00;
   localparam logic [6:0] NB_OP = 7'h08;
   localparam logic [6:0] NB_STAT = 7'h10;
   localparam logic [6:0] NB_WRITE = 7'h38;
   localparam logic [6:0] NB_READ = 7'h40;
   // check byte sits below the four data bytes in the captured bits
   localparam int unsigned RX_CRC_W = 8;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_WRSTAT = 3'h1,
      CMD_WRITE = 3'h2,
      CMD_READ = 3'h3,
      CMD_WRDIS = 3'h4,
      CMD_RDSTAT = 3'h5,
      CMD_WREN = 3'h6,
      CMD_RSVD = 3'h7
   } secp_cmd_t;
endpackage : secp_pkg

// *** core/secp_shifter.sv ***
// spi mode 0 shift engine: sends tx bits msb first, captures rx bits
module secp_shifter #(
   parameter int unsigned MAXB = 64
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [MAXB-1:0] tx_bits,
   input wire logic [6:0] nbits,
   input wire logic miso,
   output logic sck,
   output logic mosi,
   output logic cs_n,
   output logic done,
   output logic [MAXB-1:0] rx_bits
);
   logic [MAXB-1:0] sh_ff, nxt_sh;
   logic [MAXB-1:0] rx_ff, nxt_rx;
   logic [6:0] cnt_ff, nxt_cnt;
   logic [1:0] div_ff, nxt_div;
   logic busy_ff, nxt_busy;
   logic sck_ff, nxt_sck;
   logic done_ff, nxt_done;

   always_comb begin
      nxt_sh = sh_ff;
      nxt_rx = rx_ff;
      nxt_cnt = cnt_ff;
      nxt_div = div_ff;
      nxt_busy = busy_ff;
      nxt_sck = sck_ff;
      nxt_done = 1'b0;
      if (!busy_ff) begin
         if (start) begin
            nxt_sh = tx_bits;
            nxt_rx = '0;
            nxt_cnt = nbits;
            nxt_div = '0;
            nxt_busy = 1'b1;
         end
      end else if (div_ff == 2'(secp_pkg::SCK_HALF - 1)) begin
         nxt_div = '0;
         if (!sck_ff) begin
            nxt_sck = 1'b1;
            nxt_rx = {rx_ff[MAXB-2:0], miso};
         end else begin
            nxt_sck = 1'b0;
            nxt_sh = {sh_ff[MAXB-2:0], 1'b0};
            nxt_cnt = cnt_ff - 7'h01;
            if (cnt_ff == 7'h01) begin
               nxt_busy = 1'b0;
               nxt_done = 1'b1;
            end
         end
      end else begin
         nxt_div = div_ff + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_ff <= '0;
         rx_ff <= '0;
         cnt_ff <= '0;
         div_ff <= '0;
         busy_ff <= 1'b0;
         sck_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         sh_ff <= nxt_sh;
         rx_ff <= nxt_rx;
         cnt_ff <= nxt_cnt;
         div_ff <= nxt_div;
         busy_ff <= nxt_busy;
         sck_ff <= nxt_sck;
         done_ff <= nxt_done;
      end
   end

   assign sck = sck_ff;
   assign mosi = sh_ff[MAXB-1];
   assign cs_n = ~busy_ff;
   assign done = done_ff;
   assign rx_bits = rx_ff;
endmodule : secp_shifter

// *** sim/secp_port_properties.sv ***
// port checker for the serial eeprom command port
module secp_port_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic eep_sck,
   input wire logic eep_mosi,
   input wire logic eep_cs_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response not held");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data not held");
   AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready longer than one cycle");
   AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
   AST_R_ANSWER: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |-> ##[1:2] s_axi_rvalid) else $error("read not answered");
   AST_NO_TAKE: assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid
      |=> s_axi_bvalid) else $error("held write not answered next cycle");
   AST_SCK_IDLE: assert property (eep_cs_n |-> !eep_sck)
      else $error("serial clock moves outside frame");
   AST_SCK_HALF: assert property ($rose(eep_sck) |=> eep_sck ##1 !eep_sck)
      else $error("serial clock high phase wrong");
   AST_MOSI_SETUP: assert property ($rose(eep_sck) |-> $stable(eep_mosi))
      else $error("serial data changed at rising clock");
   cover property ($fell(eep_cs_n));
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (s_axi_rvalid && s_axi_rdata[19:18] == 2'h2);
endmodule : secp_port_chk

bind secp_port secp_port_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .eep_sck(eep_sck), .eep_mosi(eep_mosi), .eep_cs_n(eep_cs_n));

// *** sim/secp_eeprom_model.sv ***
// behavioural spi eeprom on the far side of the command port
module secp_eeprom_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic cs_n,
   input wire logic crc_bad,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] stat_ff = 8'h00;
   logic [31:0] mem [int];
   logic [55:0] in_sr = '0;
   logic [39:0] out_sr = '0;
   logic [31:0] d;
   logic [7:0] c;
   int n = 0;
   initial miso = 1'b0;
   always @(negedge cs_n) n = 0;
   always @(posedge sck) begin
      in_sr = {in_sr[54:0], mosi};
      n++;
      // ready bit stays 0 and write cycle bits 000: no internal write time modelled
      if (n == 8 && in_sr[7:0] == 8'h05) out_sr = {stat_ff, 32'h0};
      if (n == 24 && in_sr[23:16] == 8'h03) begin
         d = mem.exists(int'(in_sr[15:0])) ? mem[int'(in_sr[15:0])] : 32'h0;
         c = 8'h00;
         for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
         out_sr = {d, c ^ {8{crc_bad}}};
      end
   end
   always @(negedge sck) if (!cs_n) begin
      miso = out_sr[39];
      out_sr = {out_sr[38:0], ~out_sr[0]};
   end
   always @(posedge cs_n) begin
      // no pull on the line, so a released output shows the inverse
      miso = ~miso;
      if (n == 8 && in_sr[7:0] == 8'h06) stat_ff[1] = 1'b1;
      if (n == 8 && in_sr[7:0] == 8'h04) stat_ff[1] = 1'b0;
      if (n == 56 && in_sr[55:48] == 8'h02 && stat_ff[1]) begin
         mem[int'(in_sr[47:32])] = in_sr[31:0];
         stat_ff[1] = 1'b0;
      end
      // protect pin taken as high, so only the latch gates status writes
      if (n == 16 && in_sr[15:8] == 8'h01 && stat_ff[1]) begin
         stat_ff = (stat_ff & 8'h73) | (in_sr[7:0] & 8'h8C);
         stat_ff[1] = 1'b0;
      end
   end
endmodule : secp_eeprom_model

// *** sim/secp_port_tb.sv ***
// self-checking bench for the serial eeprom command port
module secp_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [1:0] rs;} secp_row_t;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] aw_a = 12'h000;
   logic [11:0] ar_a = 12'h000;
   logic [31:0] w_d = 32'h0;
   logic [3:0] strb = 4'hF;
   logic aw_v = 1'b0;
   logic w_v = 1'b0;
   logic ar_v = 1'b0;
   logic b_rdy = 1'b1;
   logic r_rdy = 1'b1;
   logic present = 1'b1;
   logic crc_bad = 1'b0;
   logic aw_r, w_r, b_v, ar_r, r_v, sck, mosi, cs_n, miso;
   logic [1:0] b_r, r_r;
   logic [31:0] rd;
   int errors = 0;
   int samples_checked = 0;
   secp_row_t rows [8] = '{
      '{1'b0, 12'h260, 32'h0001_0000, 2'h0},
      '{1'b0, 12'h264, 32'h0000_0000, 2'h0},
      '{1'b1, 12'h264, 32'hA5C3_9E17, 2'h0},
      '{1'b0, 12'h264, 32'hA5C3_9E17, 2'h0},
      '{1'b1, 12'h260, 32'h0030_1FFF, 2'h0},
      '{1'b0, 12'h260, 32'h0031_1FFF, 2'h0},
      '{1'b1, 12'h26C, 32'h1234_5678, 2'h2},
      '{1'b0, 12'h26C, 32'h0000_0000, 2'h2}};

   secp_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(aw_a),
      .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(strb),
      .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_r), .s_axi_bvalid(b_v),
      .s_axi_bready(b_rdy), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(rd), .s_axi_rresp(r_r), .s_axi_rvalid(r_v),
      .s_axi_rready(r_rdy), .eep_present(present), .eep_miso(miso), .eep_sck(sck),
      .eep_mosi(mosi), .eep_cs_n(cs_n));
   secp_eeprom_model u_part (.sck(sck), .mosi(mosi), .cs_n(cs_n), .crc_bad(crc_bad),
      .miso(miso));

   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // handshakes are judged at the falling edge, where ready flops are settled
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(negedge core_clk);
         ta = aw_v && aw_r;
         tw = w_v && w_r;
         tb = b_v;
         r = b_r;
         @(posedge core_clk);
         if (ta) aw_v <= 1'b0;
         if (tw) w_v <= 1'b0;
         if (tb) return;
      end
      errors++;
      end_sim();
   endtask : axw

   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      ar_a <= a;
      ar_v <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(negedge core_clk);
         ta = ar_v && ar_r;
         tr = r_v;
         d = rd;
         r = r_r;
         @(posedge core_clk);
         if (ta) ar_v <= 1'b0;
         // let an edge pass so a following read never rewrites arvalid in this step
         if (tr) begin
            if (ta) @(posedge core_clk);
            return;
         end
      end
      errors++;
      end_sim();
   endtask : axr

   task automatic cmd(input logic [2:0] c, input logic [7:0] s, input logic [31:0] lo,
                      output logic [31:0] v);
      logic [1:0] r;
      axw(12'h260, {s, 24'h0} | lo | (32'(c) << 13), r);
      axr(12'h260, v, r);
      chk({30'h0, v[19:18]}, 32'h1);
      for (int k = 0; k < 200 && v[19:18] == 2'h1; k++) axr(12'h260, v, r);
      if (v[19:18] == 2'h1) begin
         errors++;
         end_sim();
      end
   endtask : cmd

   initial begin
      logic [31:0] v;
      logic [1:0] r;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      foreach (rows[i]) begin
         if (rows[i].w) axw(rows[i].a, rows[i].d, r);
         else begin
            axr(rows[i].a, v, r);
            chk(v, rows[i].d);
         end
         chk({30'h0, r}, {30'h0, rows[i].rs});
      end
      $display("register table done");
      cmd(3'h6, 8'h00, 32'h0, v);
      cmd(3'h5, 8'h00, 32'h0, v);
      chk({24'h0, v[31:24]}, 32'h02);
      cmd(3'h4, 8'h00, 32'h0, v);
      cmd(3'h5, 8'h00, 32'h0, v);
      chk({24'h0, v[31:24]}, 32'h00);
      $display("latch test done");
      axw(12'h264, 32'h3C5A_0FF1, r);
      cmd(3'h6, 8'h00, 32'h0, v);
      cmd(3'h2, 8'h00, 32'h0010_1ABC, v);
      axw(12'h264, 32'h0, r);
      cmd(3'h3, 8'h00, 32'h0010_1ABC, v);
      axr(12'h264, v, r);
      chk(v, 32'h3C5A_0FF1);
      crc_bad <= 1'b1;
      cmd(3'h3, 8'h00, 32'h0010_1ABC, v);
      chk({28'h0, v[19:16]}, 32'hB);
      cmd(3'h3, 8'h00, 32'h0030_1ABC, v);
      chk({28'h0, v[19:16]}, 32'h1);
      crc_bad <= 1'b0;
      $display("memory test done");
      cmd(3'h6, 8'h00, 32'h0, v);
      cmd(3'h1, 8'hFF, 32'h0, v);
      cmd(3'h5, 8'h00, 32'h0, v);
      chk({24'h0, v[31:24]}, 32'h8C);
      $display("status test done");
      present <= 1'b0;
      repeat (2) @(posedge core_clk);
      axr(12'h260, v, r);
      chk({30'h0, v[17:16]}, 32'h0);
      rst_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      present <= 1'b1;
      @(posedge core_clk);
      axr(12'h264, v, r);
      chk(v, 32'h0);
      $display("reset test done");
      end_sim();
   end
endmodule : secp_port_tb
